// file: verilog/supply_voltage_monitor_ctrl.sv
// Functional notes
// - monitor 1 threshold code takes only 0100, 0101, 0110, 1010, 1011
// - monitor 2 threshold code sits in level register bits 7 to 4
// - monitor 0 threshold from option bits, codes 10 and 11 usable only
// - monitors 1, 2 reset while low, release after rise or from drop
// - monitor 0 holds reset while low, releases after delay above threshold
// - interrupt mode raises non-maskable or maskable request per monitor
// - interrupt on falling, rising or both crossings per monitor
// - monitor 0 has no filter, interrupt or flag; reset only
// - filter samples low-speed clock divided by 2, 4, 8 or 16, twice
// - filter-disable bit 0 filters, 1 passes raw comparator result
// - monitor 2 owns its filter-disable and sample-clock fields
// - monitors 1 and 2 emit event pulses on crossings, monitor 0 none
// - select bit chooses reset (1) or interrupt (0), changed while disabled
// - compare-output enable gates comparator to crossing flag, events and actions
`timescale 1ns/1ns
module supply_voltage_monitor_ctrl #(
  parameter int RELEASE_CYCLES = svm_pkg::RELEASE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmp0Above,
  input wire logic cmp1Above,
  input wire logic cmp2Above,
  input wire logic lowOscTick,
  input wire logic [31:0] optionSettingWord,
  output logic [1:0] mon0ThresholdCode,
  output logic [3:0] mon1ThresholdCode,
  output logic [3:0] mon2ThresholdCode,
  output logic mon1CircuitEnable,
  output logic mon2CircuitEnable,
  output logic supplyReset,
  output logic nmiRequest,
  output logic irqRequest1,
  output logic irqRequest2,
  output logic event1,
  output logic event2
);
  logic [7:0] levelSel;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] ctrl1b;
  logic [7:0] ctrl2b;
  logic [1:0] circEn;
  logic [31:0] optWord;
  logic optLoaded;
  logic mon0Legal;
  logic mon0Hold;
  logic [svm_pkg::REL_W-1:0] mon0Count;
  logic addrPhase;
  logic wrPending;
  logic rdWait;
  logic [7:0] regAddr;
  logic [31:0] rdValue;
  logic wrLevel;
  logic wrCtrl1;
  logic wrCtrl2;
  logic clear1;
  logic clear2;
  logic mon1Level;
  logic mon2Level;
  logic mon1Det;
  logic mon2Det;
  logic mon1Rst;
  logic mon2Rst;
  logic mon1Nmi;
  logic mon2Nmi;

  // bus address phase and data phase tracking
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = !rdWait;
  assign hresp = 1'b0;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPending <= 1'b0;
      rdWait <= 1'b0;
      regAddr <= 8'h00;
    end
    else
    begin
      wrPending <= addrPhase && hwrite;
      rdWait <= addrPhase && !hwrite;
      if (addrPhase)
        regAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (rdWait)
      hrdata <= rdValue;
  end

  always_comb
  begin
    rdValue = 32'h00000000;
    if (regAddr == svm_pkg::ADDR_LEVEL)
      rdValue = {24'h000000, levelSel};
    else if (regAddr == svm_pkg::ADDR_CTRL1)
      rdValue = {24'h000000, ctrl1};
    else if (regAddr == svm_pkg::ADDR_CTRL2)
      rdValue = {24'h000000, ctrl2};
    else if (regAddr == svm_pkg::ADDR_CIRC)
      rdValue = {30'h00000000, circEn};
    else if (regAddr == svm_pkg::ADDR_STAT1)
      rdValue = {30'h00000000, mon1Level, mon1Det};
    else if (regAddr == svm_pkg::ADDR_STAT2)
      rdValue = {30'h00000000, mon2Level, mon2Det};
    else if (regAddr == svm_pkg::ADDR_CTRL1B)
      rdValue = {24'h000000, ctrl1b};
    else if (regAddr == svm_pkg::ADDR_CTRL2B)
      rdValue = {24'h000000, ctrl2b};
    else if (regAddr == svm_pkg::ADDR_OPT)
      rdValue = optWord;
  end

  // write decodes
  assign wrLevel = wrPending && regAddr == svm_pkg::ADDR_LEVEL;
  assign wrCtrl1 = wrPending && regAddr == svm_pkg::ADDR_CTRL1;
  assign wrCtrl2 = wrPending && regAddr == svm_pkg::ADDR_CTRL2;
  assign clear1 = wrPending && regAddr == svm_pkg::ADDR_STAT1 && !hwdata[svm_pkg::ST_DET];
  assign clear2 = wrPending && regAddr == svm_pkg::ADDR_STAT2 && !hwdata[svm_pkg::ST_DET];

  // threshold codes, illegal codes are not stored
  always_ff @(posedge mclk)
  begin
    if (rst)
      levelSel <= svm_pkg::LEVEL_RESET;
    else if (wrLevel)
    begin
      if (svm_pkg::legal_code(hwdata[3:0]))
        levelSel[3:0] <= hwdata[3:0];
      if (svm_pkg::legal_code(hwdata[7:4]))
        levelSel[7:4] <= hwdata[7:4];
    end
  end

  // control 0; reset/interrupt select locked while action enabled
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl1 <= svm_pkg::CTRL_RESET;
    else if (wrCtrl1)
    begin
      ctrl1 <= {2'h0, hwdata[5:4], ctrl1[svm_pkg::CR_RI], hwdata[2:0]};
      if (!ctrl1[svm_pkg::CR_RIE])
        ctrl1[svm_pkg::CR_RI] <= hwdata[svm_pkg::CR_RI];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl2 <= svm_pkg::CTRL_RESET;
    else if (wrCtrl2)
    begin
      ctrl2 <= {2'h0, hwdata[5:4], ctrl2[svm_pkg::CR_RI], hwdata[2:0]};
      if (!ctrl2[svm_pkg::CR_RIE])
        ctrl2[svm_pkg::CR_RI] <= hwdata[svm_pkg::CR_RI];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl1b <= svm_pkg::CTRLB_RESET;
      ctrl2b <= svm_pkg::CTRLB_RESET;
      circEn <= svm_pkg::CIRC_RESET;
    end
    else if (wrPending)
    begin
      if (regAddr == svm_pkg::ADDR_CTRL1B)
        ctrl1b <= {4'h0, hwdata[3:0]};
      if (regAddr == svm_pkg::ADDR_CTRL2B)
        ctrl2b <= {4'h0, hwdata[3:0]};
      if (regAddr == svm_pkg::ADDR_CIRC)
        circEn <= hwdata[1:0];
    end
  end

  // option word caught after reset release
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      optLoaded <= 1'b0;
      optWord <= 32'h00000000;
    end
    else if (!optLoaded)
    begin
      optLoaded <= 1'b1;
      optWord <= optionSettingWord;
    end
  end

  assign mon0ThresholdCode = optWord[svm_pkg::OPT_MON0_LSB +: 2];
  assign mon0Legal = optLoaded && mon0ThresholdCode[1];

  // monitor 0: reset only, no filter, flag or event
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mon0Hold <= 1'b1;
      mon0Count <= '0;
    end
    else if (optLoaded)
    begin
      if (!mon0Legal)
        mon0Hold <= 1'b0;
      else if (!cmp0Above)
      begin
        mon0Hold <= 1'b1;
        mon0Count <= '0;
      end
      else if (mon0Hold)
      begin
        mon0Count <= mon0Count + 1'b1;
        if (mon0Count == svm_pkg::REL_W'(RELEASE_CYCLES - 1))
          mon0Hold <= 1'b0;
      end
    end
  end

  svm_monitor #(.RELEASE_CYCLES(RELEASE_CYCLES)) mon1 (
    .mclk(mclk),
    .rst(rst),
    .cmpAbove(cmp1Above),
    .lowOscTick(lowOscTick),
    .circuitEnable(circEn[svm_pkg::CIRC_E1]),
    .compareOutEnable(ctrl1[svm_pkg::CR_CMPE]),
    .filterDisable(ctrl1[svm_pkg::CR_FDIS]),
    .sampleClockSel(ctrl1[svm_pkg::CR_FSAMP_LO +: 2]),
    .resetOrIrqSel(ctrl1[svm_pkg::CR_RI]),
    .actionEnable(ctrl1[svm_pkg::CR_RIE]),
    .nmiSel(ctrl1b[svm_pkg::CRB_NMI]),
    .edgeSel(ctrl1b[svm_pkg::CRB_EDGE_LO +: 2]),
    .releaseMode(ctrl1b[svm_pkg::CRB_RN]),
    .clearCrossing(clear1),
    .levelFlag(mon1Level),
    .crossingFlag(mon1Det),
    .resetReq(mon1Rst),
    .nmiPulse(mon1Nmi),
    .irqPulse(irqRequest1),
    .eventPulse(event1)
  );

  svm_monitor #(.RELEASE_CYCLES(RELEASE_CYCLES)) mon2 (
    .mclk(mclk),
    .rst(rst),
    .cmpAbove(cmp2Above),
    .lowOscTick(lowOscTick),
    .circuitEnable(circEn[svm_pkg::CIRC_E2]),
    .compareOutEnable(ctrl2[svm_pkg::CR_CMPE]),
    .filterDisable(ctrl2[svm_pkg::CR_FDIS]),
    .sampleClockSel(ctrl2[svm_pkg::CR_FSAMP_LO +: 2]),
    .resetOrIrqSel(ctrl2[svm_pkg::CR_RI]),
    .actionEnable(ctrl2[svm_pkg::CR_RIE]),
    .nmiSel(ctrl2b[svm_pkg::CRB_NMI]),
    .edgeSel(ctrl2b[svm_pkg::CRB_EDGE_LO +: 2]),
    .releaseMode(ctrl2b[svm_pkg::CRB_RN]),
    .clearCrossing(clear2),
    .levelFlag(mon2Level),
    .crossingFlag(mon2Det),
    .resetReq(mon2Rst),
    .nmiPulse(mon2Nmi),
    .irqPulse(irqRequest2),
    .eventPulse(event2)
  );

  assign mon1ThresholdCode = levelSel[3:0];
  assign mon2ThresholdCode = levelSel[7:4];
  assign mon1CircuitEnable = circEn[svm_pkg::CIRC_E1];
  assign mon2CircuitEnable = circEn[svm_pkg::CIRC_E2];
  assign supplyReset = mon0Hold || mon1Rst || mon2Rst;
  assign nmiRequest = mon1Nmi || mon2Nmi;

  AST_LEVEL1_LEGAL: assert property (@(posedge mclk) disable iff (rst)
    wrLevel && !svm_pkg::legal_code(hwdata[3:0]) |=> $stable(levelSel[3:0]))
    else $error("illegal monitor 1 code stored");
  AST_LEVEL2_LEGAL: assert property (@(posedge mclk) disable iff (rst)
    wrLevel && svm_pkg::legal_code(hwdata[7:4]) |=> levelSel[7:4] == $past(hwdata[7:4]))
    else $error("legal monitor 2 code not stored");
  AST_MON0_RESERVED: assert property (@(posedge mclk) disable iff (rst)
    optLoaded && !mon0ThresholdCode[1] |=> !mon0Hold)
    else $error("monitor 0 active with reserved code");
  AST_MON0_HOLD: assert property (@(posedge mclk) disable iff (rst)
    mon0Legal && !cmp0Above |=> supplyReset ##1 supplyReset)
    else $error("monitor 0 reset not held");
  AST_MON0_NO_EARLY: assert property (@(posedge mclk) disable iff (rst)
    mon0Legal && mon0Hold && cmp0Above && mon0Count == '0 |-> mon0Hold [*8])
    else $error("monitor 0 released too early");
  AST_RI_LOCK: assert property (@(posedge mclk) disable iff (rst)
    wrCtrl1 && ctrl1[svm_pkg::CR_RIE] |=> $stable(ctrl1[svm_pkg::CR_RI]))
    else $error("reset select changed while action enabled");
  AST_READ_WAIT: assert property (@(posedge mclk) disable iff (rst)
    addrPhase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
endmodule

// file: verilog/svm_pkg.sv
package svm_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ADDR_LEVEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_CIRC = 8'h0C;
  localparam logic [7:0] ADDR_STAT1 = 8'h10;
  localparam logic [7:0] ADDR_STAT2 = 8'h14;
  localparam logic [7:0] ADDR_CTRL1B = 8'h18;
  localparam logic [7:0] ADDR_CTRL2B = 8'h1C;
  localparam logic [7:0] ADDR_OPT = 8'h20;
  // control 0 fields
  localparam int CR_FDIS = 0;
  localparam int CR_FSAMP_LO = 1;
  localparam int CR_RI = 3;
  localparam int CR_RIE = 4;
  localparam int CR_CMPE = 5;
  // control 1 fields
  localparam int CRB_EDGE_LO = 0;
  localparam int CRB_NMI = 2;
  localparam int CRB_RN = 3;
  // status, circuit enable and option fields
  localparam int ST_DET = 0;
  localparam int ST_MON = 1;
  localparam int CIRC_E1 = 0;
  localparam int CIRC_E2 = 1;
  localparam int OPT_MON0_LSB = 0;
  // reset values
  localparam logic [7:0] LEVEL_RESET = 8'h44;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] CTRLB_RESET = 8'h00;
  localparam logic [1:0] CIRC_RESET = 2'h0;
  // edge selections
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RELEASE_DELAY_NS = 100000;
  localparam int RELEASE_CYCLES = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_W = 12;
  // reset hold sequence of monitors 1 and 2
  typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_HOLD = 2'b01, RS_COUNT = 2'b11} rst_state_e;

  function automatic logic legal_code(input logic [3:0] c);
    return (c == 4'h4) || (c == 4'h5) || (c == 4'h6) || (c == 4'hA) || (c == 4'hB);
  endfunction
endpackage

// file: verilog/svm_monitor.sv
`timescale 1ns/1ns
module svm_monitor #(
  parameter int RELEASE_CYCLES = svm_pkg::RELEASE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmpAbove,
  input wire logic lowOscTick,
  input wire logic circuitEnable,
  input wire logic compareOutEnable,
  input wire logic filterDisable,
  input wire logic [1:0] sampleClockSel,
  input wire logic resetOrIrqSel,
  input wire logic actionEnable,
  input wire logic nmiSel,
  input wire logic [1:0] edgeSel,
  input wire logic releaseMode,
  input wire logic clearCrossing,
  output logic levelFlag,
  output logic crossingFlag,
  output logic resetReq,
  output logic nmiPulse,
  output logic irqPulse,
  output logic eventPulse
);
  logic [3:0] divCount;
  logic [4:0] divisor;
  logic sampTick;
  logic sampA;
  logic filtLevel;
  logic rawLevel;
  logic prevLevel;
  logic active;
  logic riseEdge;
  logic fallEdge;
  logic edgeHit;
  logic armed;
  logic relDone;
  logic [svm_pkg::REL_W-1:0] relCount;
  svm_pkg::rst_state_e rstState;

  // divided low-speed clock, n = 2, 4, 8, 16
  assign divisor = 5'h02 << sampleClockSel;
  assign sampTick = lowOscTick && ({1'b0, divCount} == divisor - 5'h01);

  always_ff @(posedge mclk)
  begin
    if (rst || filterDisable)
      divCount <= 4'h0;
    else if (lowOscTick)
      divCount <= sampTick ? 4'h0 : divCount + 4'h1;
  end

  // two agreeing samples make a decision
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sampA <= 1'b0;
      filtLevel <= 1'b0;
    end
    else if (filterDisable)
    begin
      sampA <= cmpAbove;
      filtLevel <= cmpAbove;
    end
    else if (sampTick)
    begin
      sampA <= cmpAbove;
      if (cmpAbove == sampA)
        filtLevel <= cmpAbove;
    end
  end

  assign rawLevel = filterDisable ? cmpAbove : filtLevel;
  assign active = circuitEnable && compareOutEnable;
  assign riseEdge = active && rawLevel && !prevLevel;
  assign fallEdge = active && !rawLevel && prevLevel;
  assign edgeHit = (riseEdge && edgeSel != svm_pkg::EDGE_FALL)
    || (fallEdge && edgeSel != svm_pkg::EDGE_RISE);
  assign armed = active && actionEnable && resetOrIrqSel;
  assign relDone = relCount == svm_pkg::REL_W'(RELEASE_CYCLES - 1);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prevLevel <= 1'b1;
      levelFlag <= 1'b0;
    end
    else
    begin
      prevLevel <= rawLevel;
      if (circuitEnable)
        levelFlag <= rawLevel;
    end
  end

  // sticky crossing flag, a new crossing beats the clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      crossingFlag <= 1'b0;
    else if (riseEdge || fallEdge)
      crossingFlag <= 1'b1;
    else if (clearCrossing)
      crossingFlag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      eventPulse <= 1'b0;
      nmiPulse <= 1'b0;
      irqPulse <= 1'b0;
    end
    else
    begin
      eventPulse <= riseEdge || fallEdge;
      nmiPulse <= edgeHit && actionEnable && !resetOrIrqSel && nmiSel;
      irqPulse <= edgeHit && actionEnable && !resetOrIrqSel && !nmiSel;
    end
  end

  // reset hold: release after rise (mode 0) or counted from drop (mode 1)
  always_ff @(posedge mclk)
  begin
    if (rst || !armed)
    begin
      rstState <= svm_pkg::RS_IDLE;
      relCount <= '0;
    end
    else
    begin
      case (rstState)
        svm_pkg::RS_IDLE:
        begin
          relCount <= '0;
          if (!rawLevel && (!releaseMode || fallEdge))
            rstState <= releaseMode ? svm_pkg::RS_COUNT : svm_pkg::RS_HOLD;
        end
        svm_pkg::RS_HOLD:
        begin
          relCount <= '0;
          if (rawLevel)
            rstState <= svm_pkg::RS_COUNT;
        end
        svm_pkg::RS_COUNT:
        begin
          relCount <= relCount + 1'b1;
          if (!rawLevel && !releaseMode)
            rstState <= svm_pkg::RS_HOLD;
          else if (relDone)
            rstState <= svm_pkg::RS_IDLE;
        end
        default:
          rstState <= svm_pkg::RS_IDLE;
      endcase
    end
  end

  assign resetReq = rstState != svm_pkg::RS_IDLE;

  AST_DET_STICKY: assert property (@(posedge mclk) disable iff (rst)
    crossingFlag && !clearCrossing |=> crossingFlag)
    else $error("crossing flag dropped without a clear");
  AST_EVENT_PULSE: assert property (@(posedge mclk) disable iff (rst)
    (riseEdge || fallEdge) |=> eventPulse && crossingFlag
    ##1 (eventPulse == $past(riseEdge || fallEdge)))
    else $error("crossing did not give one event pulse");
  AST_EDGE_FILTER: assert property (@(posedge mclk) disable iff (rst)
    riseEdge && edgeSel == svm_pkg::EDGE_FALL |=> !nmiPulse && !irqPulse)
    else $error("interrupt on an unselected edge");
  AST_RESET_LOW: assert property (@(posedge mclk) disable iff (rst)
    armed && !rawLevel && !releaseMode ##1 armed |-> resetReq)
    else $error("reset not held while supply low");
  AST_FILTER_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !filterDisable && !sampTick |=> $stable(filtLevel))
    else $error("filter changed between sampling ticks");
endmodule

// file: verification/supply_sense_model.sv
`timescale 1ns/1ns
module supply_sense_model #(
  parameter int LOSC_DIV = 4
) (
  input wire logic mclk,
  input wire logic [2:0] supplyAbove,
  input wire logic circ1En,
  input wire logic circ2En,
  output logic cmp0Above,
  output logic cmp1Above,
  output logic cmp2Above,
  output logic lowOscTick
);
  int divCnt = 0;
  logic junk = 1'b0;
  // low-speed oscillator tick and a wandering level for idle comparators
  always @(posedge mclk)
  begin
    junk <= ~junk;
    divCnt <= (divCnt == LOSC_DIV - 1) ? 0 : divCnt + 1;
  end
  assign lowOscTick = (divCnt == 0);
  assign cmp0Above = supplyAbove[0];
  assign cmp1Above = circ1En ? supplyAbove[1] : junk;
  assign cmp2Above = circ2En ? supplyAbove[2] : junk;
endmodule

// file: verification/supply_voltage_monitor_ctrl_tb_top.sv
`timescale 1ns/1ns
module supply_voltage_monitor_ctrl_tb_top;
  localparam int REL = 8;
  localparam int LD = 4;
  localparam int SETTLE = 20;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] exp;
  } row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] supplyAbove = 3'h7;
  logic [31:0] optionWord = 32'h3;
  logic hreadyout, hresp, cmp0Above, cmp1Above, cmp2Above, lowOscTick;
  logic circ1, circ2, supplyReset, nmiRequest, irqRequest1, irqRequest2, event1, event2;
  logic [31:0] hrdata, rd, expLvl;
  logic [1:0] mon0Code;
  logic [3:0] mon1Code, mon2Code;
  int nErrors = 0, nTests = 0, nmiCnt = 0, irq1Cnt = 0, irq2Cnt = 0, ev1Cnt = 0, ev2Cnt = 0;
  int cyc, b0, b1, b2, n;
  row_s rows [8];
  logic [1:0] edges [3];
  int irqExp [3];

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  supply_sense_model #(.LOSC_DIV(LD)) supply_sense_model_inst (
    .mclk(mclk),
    .supplyAbove(supplyAbove),
    .circ1En(circ1),
    .circ2En(circ2),
    .cmp0Above(cmp0Above),
    .cmp1Above(cmp1Above),
    .cmp2Above(cmp2Above),
    .lowOscTick(lowOscTick)
  );

  supply_voltage_monitor_ctrl #(.RELEASE_CYCLES(REL)) supply_voltage_monitor_ctrl_inst (
    .mclk(mclk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cmp0Above(cmp0Above),
    .cmp1Above(cmp1Above),
    .cmp2Above(cmp2Above),
    .lowOscTick(lowOscTick),
    .optionSettingWord(optionWord),
    .mon0ThresholdCode(mon0Code),
    .mon1ThresholdCode(mon1Code),
    .mon2ThresholdCode(mon2Code),
    .mon1CircuitEnable(circ1),
    .mon2CircuitEnable(circ2),
    .supplyReset(supplyReset),
    .nmiRequest(nmiRequest),
    .irqRequest1(irqRequest1),
    .irqRequest2(irqRequest2),
    .event1(event1),
    .event2(event2)
  );

  // pulse counters, a level would count many times
  always @(posedge mclk)
  begin
    if (nmiRequest === 1'b1) nmiCnt++;
    if (irqRequest1 === 1'b1) irq1Cnt++;
    if (irqRequest2 === 1'b1) irq2Cnt++;
    if (event1 === 1'b1) ev1Cnt++;
    if (event2 === 1'b1) ev2Cnt++;
  end

  function automatic logic okCode(input logic [3:0] c);
    return c inside {4'h4, 4'h5, 4'h6, 4'hA, 4'hB};
  endfunction

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // one single AHB transfer, read data left in rd
  task busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // let the written register settle before any check
    @(negedge mclk);
  endtask

  task setSup(input int i, input logic v);
    @(posedge mclk);
    supplyAbove[i] <= v;
  endtask

  task waitRst(input logic v);
    cyc = 0;
    while (supplyReset !== v && cyc < 300)
    begin
      @(negedge mclk);
      cyc++;
    end
  endtask

  task endOfTest;
    if (nErrors == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    nErrors++;
    endOfTest;
  end

  initial
  begin
    rows = '{
      '{svm_pkg::ADDR_LEVEL, 32'h5B, svm_pkg::ADDR_LEVEL, 32'h5B},
      '{svm_pkg::ADDR_LEVEL, 32'h37, svm_pkg::ADDR_LEVEL, 32'h5B},
      '{svm_pkg::ADDR_LEVEL, 32'hA3, svm_pkg::ADDR_LEVEL, 32'hAB},
      '{svm_pkg::ADDR_CTRL1, 32'h06, svm_pkg::ADDR_CTRL2, 32'h01},
      '{svm_pkg::ADDR_CTRL2, 32'h05, svm_pkg::ADDR_CTRL1, 32'h06},
      '{svm_pkg::ADDR_OPT, 32'hFF, svm_pkg::ADDR_OPT, 32'h03},
      '{8'h24, 32'hFF, 8'h24, 32'h00},
      '{svm_pkg::ADDR_CTRL1B, 32'h0F, svm_pkg::ADDR_CTRL1B, 32'h0F}};
    edges = '{svm_pkg::EDGE_BOTH, svm_pkg::EDGE_FALL, svm_pkg::EDGE_RISE};
    irqExp = '{2, 1, 1};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    waitRst(1'b0);
    chk("rel0", 1, cyc >= REL && cyc <= REL + 4);
    chk("code0", 2'h3, mon0Code);
    chk("hresp", 0, hresp);
    busXfer(1'b0, svm_pkg::ADDR_LEVEL, 32'h0);
    chk("lvlRst", svm_pkg::LEVEL_RESET, rd);
    busXfer(1'b0, svm_pkg::ADDR_CTRL2, 32'h0);
    chk("ctl2Rst", svm_pkg::CTRL_RESET, rd);
    b0 = ev1Cnt + ev2Cnt + irq1Cnt + irq2Cnt + nmiCnt;
    setSup(0, 1'b0);
    repeat (4) @(negedge mclk);
    chk("drop0", 1, supplyReset);
    setSup(0, 1'b1);
    waitRst(1'b0);
    chk("relTime0", 1, cyc >= REL && cyc <= REL + 4);
    chk("quiet0", b0, ev1Cnt + ev2Cnt + irq1Cnt + irq2Cnt + nmiCnt);
    foreach (rows[i])
    begin
      busXfer(1'b1, rows[i].wa, rows[i].wd);
      busXfer(1'b0, rows[i].ra, 32'h0);
      chk("row", rows[i].exp, rd);
    end
    expLvl = 32'hAB;
    for (int c = 0; c < 16; c++)
    begin
      busXfer(1'b1, svm_pkg::ADDR_LEVEL, {24'h0, 4'(c), 4'(c)});
      if (okCode(4'(c)))
        expLvl = {24'h0, 4'(c), 4'(c)};
      busXfer(1'b0, svm_pkg::ADDR_LEVEL, 32'h0);
      chk("level", expLvl, rd);
    end
    chk("code1", 4'hB, mon1Code);
    chk("code2", 4'hB, mon2Code);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h01);
    busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'h01);
    busXfer(1'b1, svm_pkg::ADDR_LEVEL, 32'h44);
    busXfer(1'b1, svm_pkg::ADDR_CIRC, 32'h3);
    chk("circ", 2'h3, {circ2, circ1});
    repeat (SETTLE) @(negedge mclk);
    for (int i = 0; i < 3; i++)
    begin
      busXfer(1'b1, svm_pkg::ADDR_CTRL1B, {30'h0, edges[i]});
      busXfer(1'b1, svm_pkg::ADDR_STAT1, 32'h0);
      busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h11);
      busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h31);
      b0 = ev1Cnt;
      b1 = irq1Cnt;
      b2 = nmiCnt;
      setSup(1, 1'b0);
      repeat (5) @(negedge mclk);
      busXfer(1'b0, svm_pkg::ADDR_STAT1, 32'h0);
      chk("stLow", 32'h1, rd);
      setSup(1, 1'b1);
      repeat (5) @(negedge mclk);
      busXfer(1'b0, svm_pkg::ADDR_STAT1, 32'h0);
      chk("stHigh", 32'h3, rd);
      chk("irq1", irqExp[i], irq1Cnt - b1);
      chk("ev1", 2, ev1Cnt - b0);
      chk("nmi1", 0, nmiCnt - b2);
      busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h11);
      busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h01);
      busXfer(1'b1, svm_pkg::ADDR_STAT1, 32'h0);
      busXfer(1'b0, svm_pkg::ADDR_STAT1, 32'h0);
      chk("stClr", 32'h2, rd);
    end
    busXfer(1'b1, svm_pkg::ADDR_CTRL1B, 32'h0);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h09);
    busXfer(1'b1, svm_pkg::ADDR_STAT1, 32'h0);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h19);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h39);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h31);
    busXfer(1'b0, svm_pkg::ADDR_CTRL1, 32'h0);
    chk("riLock", 32'h39, rd);
    b1 = irq1Cnt;
    setSup(1, 1'b0);
    repeat (3) @(negedge mclk);
    chk("rst1", 1, supplyReset);
    setSup(1, 1'b1);
    waitRst(1'b0);
    chk("relRise", 1, cyc >= REL && cyc <= REL + 4);
    chk("noIrq", 0, irq1Cnt - b1);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1B, 32'h08);
    setSup(1, 1'b0);
    waitRst(1'b1);
    b0 = cyc;
    waitRst(1'b0);
    chk("relDrop", 1, b0 + cyc >= REL && b0 + cyc <= REL + 5);
    setSup(1, 1'b1);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h19);
    busXfer(1'b1, svm_pkg::ADDR_CTRL1, 32'h09);
    busXfer(1'b1, svm_pkg::ADDR_CTRL2B, 32'h04);
    for (int s = 0; s < 4; s++)
    begin
      n = 2 << s;
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2 + 1));
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2));
      repeat ((2 * n + 3) * LD) @(negedge mclk);
      busXfer(1'b1, svm_pkg::ADDR_STAT2, 32'h0);
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2 + 16));
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2 + 48));
      b0 = ev2Cnt;
      b1 = nmiCnt;
      b2 = irq2Cnt;
      if (s == 0)
      begin
        setSup(2, 1'b0);
        setSup(2, 1'b1);
        repeat (60) @(negedge mclk);
        chk("glitch", 0, ev2Cnt - b0);
      end
      setSup(2, 1'b0);
      repeat (n * LD - 2) @(negedge mclk);
      chk("early", 0, ev2Cnt - b0);
      repeat (3 * n * LD + 10) @(negedge mclk);
      setSup(2, 1'b1);
      repeat (3 * n * LD + 10) @(negedge mclk);
      chk("ev2", 2, ev2Cnt - b0);
      chk("nmi2", 2, nmiCnt - b1);
      chk("irq2", 0, irq2Cnt - b2);
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2 + 16));
      repeat ((2 * n + 3) * LD) @(negedge mclk);
      busXfer(1'b1, svm_pkg::ADDR_CTRL2, 32'(s * 2 + 1));
    end
    @(posedge mclk);
    optionWord <= 32'h1;
    supplyAbove[0] <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("resv0", 0, supplyReset);
    chk("code0b", 2'h1, mon0Code);
    chk("circOff", 2'h0, {circ2, circ1});
    busXfer(1'b0, svm_pkg::ADDR_LEVEL, 32'h0);
    chk("lvlRst2", svm_pkg::LEVEL_RESET, rd);
    endOfTest;
  end
endmodule
